// ### rtl/tile_routing_pkg.sv
// Constants and types shared by the logic tile routing interface
package tile_routing_pkg;
   localparam int DP_WIDTH        = 8;
   localparam int DP_IO_COUNT     = 6;
   localparam int CFG_DEPTH       = 8;
   localparam int CFG_WIDTH       = 16;
   localparam int CFG_ADDR_WIDTH  = 3;
   localparam int REG_WIDTH       = 8;
   localparam int PORT_PINS       = 8;
   localparam int PORT_OE_COUNT   = 4;
   localparam int SUBCOMP_COUNT   = 4;
   localparam int SUB_CLK_SEL_W   = 2;
   // Configuration word fields
   localparam int CFG_OP_LSB      = 0;
   localparam int CFG_OP_MSB      = 2;
   localparam int CFG_SRC_B       = 3;
   localparam int CFG_USE_CARRY   = 4;
   localparam int CFG_SHIFT_LSB   = 5;
   localparam int CFG_SHIFT_MSB   = 6;
   localparam int CFG_DEST_A1     = 7;
   localparam int CFG_WRITE_EN    = 8;
   localparam int CFG_BANK        = 9;
   localparam logic [REG_WIDTH-1:0] CTRL_RESET  = 8'h00;
   localparam logic [DP_WIDTH-1:0]  DATA_RESET  = 8'h00;
   localparam logic [DP_WIDTH-1:0]  ALL_ONES    = 8'hFF;
   localparam logic [PORT_PINS-1:0] PINS_ZERO   = 8'h00;
   localparam logic [2:0]           SYNC_ZERO   = 3'h0;
   localparam logic [1:0]           SHIFT_NONE  = 2'h0;
   localparam logic [1:0]           SHIFT_LEFT  = 2'h1;
   localparam logic [1:0]           SHIFT_RIGHT = 2'h2;
   localparam logic [1:0]           SHIFT_SWAP  = 2'h3;
   localparam logic [1:0]           OE_GANG_ALL = 2'h0;
   localparam logic [1:0]           OE_GANG_2   = 2'h1;
   localparam logic [1:0]           OE_GANG_4   = 2'h2;
   localparam logic [1:0]           OE_SINGLE   = 2'h3;

   typedef enum logic [2:0] {
      ALU_PASS = 3'h0, ALU_INC = 3'h1, ALU_DEC = 3'h2, ALU_ADD = 3'h3,
      ALU_SUB  = 3'h4, ALU_AND = 3'h5, ALU_OR  = 3'h6, ALU_XOR = 3'h7
   } alu_op_type;

   typedef enum logic [1:0] {
      SEL_CONDITION = 2'h1,
      SEL_SERIAL    = 2'h2
   } out_sel_type;
endpackage

// ### rtl/logic_tile_routing_interface.sv
// Routing-side interface of a programmable logic tile
// Functional notes
// R1: Carry and shift-out registered for 16-bit time-multiplexing
// R2: Datapath has six routed inputs, six outputs
// R3: Routed inputs pick configuration and give serial data
// R4: Each output picks condition or serial out
// R5: Control register bus-writable, bits drive routing
// R6: Status register read-only, shows routed signals
// R7: Sticky status bit cleared by firmware read
// R8: Every register bit has programmable routing connection
// R9: Control bit usable as tile clock enable
// R10: Each subcomponent has own clock select, enable
// R11: Port takes 16 data and four drive routes
// R12: Pin output optionally pipelined one stage
// R13: Pin input optionally double-synchronised or bypassed
// R14: Pin synchronisers run on master clock
// R15: Firmware-visible pin inputs should be synchronised
// R16: Four output enables, ganged eight down to single
// R17: Configuration store eight words of sixteen bits
// R18: Control bits hold value, reset to zero
// R19: Capture set beats clearing read
module logic_tile_routing_interface
   import tile_routing_pkg::*;
#(
   parameter int CLK_SOURCES = 4
) (
   input  wire logic                                 sys_clk_i,
   input  wire logic                                 srst_i,
   // Dynamic configuration store load
   input  wire logic                                 cfg_we_i,
   input  wire logic [tile_routing_pkg::CFG_ADDR_WIDTH-1:0] cfg_waddr_i,
   input  wire logic [tile_routing_pkg::CFG_WIDTH-1:0]      cfg_wdata_i,
   // Datapath routed inputs and outputs
   input  wire logic [tile_routing_pkg::DP_IO_COUNT-1:0]    dp_route_i,
   input  wire logic [tile_routing_pkg::DP_WIDTH-1:0]       dp_par_i,
   input  wire logic [2*tile_routing_pkg::DP_IO_COUNT-1:0]  dp_out_sel_i,
   output logic      [tile_routing_pkg::DP_IO_COUNT-1:0]    dp_route_o,
   output logic      [tile_routing_pkg::DP_WIDTH-1:0]       dp_acc0_o,
   // Control and status registers
   input  wire logic                                 ctrl_wr_i,
   input  wire logic [tile_routing_pkg::REG_WIDTH-1:0]      ctrl_wdata_i,
   output logic      [tile_routing_pkg::REG_WIDTH-1:0]      ctrl_route_o,
   input  wire logic                                 stat_rd_i,
   input  wire logic [tile_routing_pkg::REG_WIDTH-1:0]      stat_route_i,
   input  wire logic [tile_routing_pkg::REG_WIDTH-1:0]      stat_sticky_mask_i,
   output logic      [tile_routing_pkg::REG_WIDTH-1:0]      stat_rdata_o,
   // Per-subcomponent clock selection
   input  wire logic [CLK_SOURCES-1:0]               clk_src_en_i,
   input  wire logic [tile_routing_pkg::SUBCOMP_COUNT*tile_routing_pkg::SUB_CLK_SEL_W-1:0] sub_clk_sel_i,
   input  wire logic [tile_routing_pkg::SUBCOMP_COUNT-1:0]  sub_en_i,
   input  wire logic [tile_routing_pkg::SUBCOMP_COUNT-1:0]  sub_ctrl_gate_i,
   input  wire logic [tile_routing_pkg::SUBCOMP_COUNT*3-1:0] sub_gate_bit_i,
   output logic      [tile_routing_pkg::SUBCOMP_COUNT-1:0]  sub_clk_en_o,
   // I/O port routing
   input  wire logic [tile_routing_pkg::PORT_PINS-1:0]      port_out_data_i,
   input  wire logic [tile_routing_pkg::PORT_PINS-1:0]      port_out_pipe_i,
   input  wire logic [3:0]                           port_drive_i,
   input  wire logic [tile_routing_pkg::PORT_OE_COUNT-1:0]  port_oe_route_i,
   input  wire logic [1:0]                           port_oe_mode_i,
   output logic      [tile_routing_pkg::PORT_PINS-1:0]      pin_out_o,
   output logic      [tile_routing_pkg::PORT_PINS-1:0]      pin_oe_o,
   output logic      [3:0]                           pin_drive_o,
   input  wire logic [tile_routing_pkg::PORT_PINS-1:0]      pin_in_i,
   input  wire logic [tile_routing_pkg::PORT_PINS-1:0]      port_in_sync_i,
   output logic      [tile_routing_pkg::PORT_PINS-1:0]      port_in_data_o
);
   import tile_routing_pkg::*;

   initial begin
      if (CLK_SOURCES < 1 || CLK_SOURCES > (1 << SUB_CLK_SEL_W)) begin
         $error("CLK_SOURCES out of range");
      end
   end

   // ************************************************
   // Shared helpers
   // ************************************************
   function automatic logic [DP_WIDTH:0] alu_fn(input logic [2:0] op, input logic [DP_WIDTH-1:0] a,
                                                 input logic [DP_WIDTH-1:0] b, input logic cin);
      logic [DP_WIDTH:0] r;
      r = '0;
      case (op)
         ALU_INC: r = {1'b0, a} + {{DP_WIDTH{1'b0}}, 1'b1} + {{DP_WIDTH{1'b0}}, cin};
         ALU_DEC: r = {1'b0, a} - {{DP_WIDTH{1'b0}}, 1'b1} - {{DP_WIDTH{1'b0}}, cin};
         ALU_ADD: r = {1'b0, a} + {1'b0, b} + {{DP_WIDTH{1'b0}}, cin};
         ALU_SUB: r = {1'b0, a} - {1'b0, b} - {{DP_WIDTH{1'b0}}, cin};
         ALU_AND: r = {1'b0, a & b};
         ALU_OR:  r = {1'b0, a | b};
         ALU_XOR: r = {1'b0, a ^ b};
         default: r = {1'b0, a};
      endcase
      return r;
   endfunction

   // ************************************************
   // Dynamic configuration store
   // ************************************************
   logic [CFG_WIDTH-1:0] cfg_mem [CFG_DEPTH];          // R17
   logic [CFG_WIDTH-1:0] cfg_word;

   always_ff @(posedge sys_clk_i) begin
      if (cfg_we_i) begin
         cfg_mem[cfg_waddr_i] <= cfg_wdata_i;
      end
   end

   // Routed inputs: [2:0] config address, [3] serial in, [4] carry in, [5] inverts configured bank
   assign cfg_word = cfg_mem[dp_route_i[CFG_ADDR_WIDTH-1:0]];  // R3 R2

   // ************************************************
   // Time-multiplexed datapath
   // ************************************************
   logic [DP_WIDTH-1:0] acc_q   [2][2];
   logic [DP_WIDTH-1:0] data_q  [2];
   logic                carry_q [2];
   logic                sout_q  [2];
   logic                bank;
   logic [DP_WIDTH-1:0] op_a, op_b, alu_r, shift_r;
   logic [DP_WIDTH:0]   alu_full;
   logic                cin, sin, sout;
   logic                dst;

   assign bank = cfg_word[CFG_BANK] ^ dp_route_i[5];
   assign dst  = cfg_word[CFG_DEST_A1];
   assign op_a = acc_q[bank][dst];
   assign op_b = cfg_word[CFG_SRC_B] ? data_q[bank] : acc_q[bank][~dst];
   // Other bank's stored carry lets low byte feed high byte next cycle
   assign cin  = cfg_word[CFG_USE_CARRY] ? carry_q[~bank] : dp_route_i[4];  // R1
   assign sin  = cfg_word[CFG_USE_CARRY] ? sout_q[~bank] : dp_route_i[3];   // R1 R3
   assign alu_full = alu_fn(cfg_word[CFG_OP_MSB:CFG_OP_LSB], op_a, op_b, cin);
   assign alu_r = alu_full[DP_WIDTH-1:0];

   always_comb begin
      shift_r = alu_r;
      sout    = 1'b0;
      case (cfg_word[CFG_SHIFT_MSB:CFG_SHIFT_LSB])
         SHIFT_LEFT:  begin shift_r = {alu_r[DP_WIDTH-2:0], sin}; sout = alu_r[DP_WIDTH-1]; end
         SHIFT_RIGHT: begin shift_r = {sin, alu_r[DP_WIDTH-1:1]}; sout = alu_r[0]; end
         SHIFT_SWAP:  shift_r = {alu_r[3:0], alu_r[7:4]};
         default:     shift_r = alu_r;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < 2; i++) begin
            acc_q[i][0] <= DATA_RESET;
            acc_q[i][1] <= DATA_RESET;
            data_q[i]   <= DATA_RESET;
            carry_q[i]  <= 1'b0;
            sout_q[i]   <= 1'b0;
         end
      end else if (sub_clk_en_o[2]) begin  // R10
         if (cfg_word[CFG_WRITE_EN]) begin
            acc_q[bank][dst] <= shift_r;
         end else begin
            data_q[bank] <= dp_par_i;
         end
         carry_q[bank] <= alu_full[DP_WIDTH];  // R1
         sout_q[bank]  <= sout;                // R1
      end
   end

   assign dp_acc0_o = acc_q[1'b0][1'b0];

   // ************************************************
   // Datapath routed outputs
   // ************************************************
   logic [DP_IO_COUNT-1:0] cond_vec, ser_vec;
   logic [DP_IO_COUNT-1:0] dp_route_q;

   assign cond_vec = {alu_full[DP_WIDTH], shift_r == ALL_ONES, shift_r == DATA_RESET,
                      op_a == op_b, op_a < op_b, carry_q[bank]};
   assign ser_vec  = {{(DP_IO_COUNT-2){sout}}, sout_q[bank], sout};

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dp_route_q <= '0;
      end else begin
         for (int i = 0; i < DP_IO_COUNT; i++) begin
            case (out_sel_type'(dp_out_sel_i[2*i +: 2]))
               SEL_CONDITION: dp_route_q[i] <= cond_vec[i];  // R4
               SEL_SERIAL:    dp_route_q[i] <= ser_vec[i];   // R4
               default:       dp_route_q[i] <= 1'b0;
            endcase
         end
      end
   end
   assign dp_route_o = dp_route_q;  // R2

   // ************************************************
   // Control and status registers
   // ************************************************
   logic [REG_WIDTH-1:0] ctrl_q, sticky_q, stat_q;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ctrl_q <= CTRL_RESET;            // R18
      end else if (ctrl_wr_i && sub_clk_en_o[3]) begin
         ctrl_q <= ctrl_wdata_i;          // R5 R18
      end
   end
   assign ctrl_route_o = ctrl_q;          // R5 R8

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sticky_q <= CTRL_RESET;
      end else begin
         // New events OR'd after the read clear so none is lost
         sticky_q <= (stat_rd_i ? CTRL_RESET : sticky_q)
                     | (stat_route_i & stat_sticky_mask_i);  // R7 R19
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         stat_q <= CTRL_RESET;
      end else begin
         stat_q <= (stat_route_i & ~stat_sticky_mask_i) | (sticky_q & stat_sticky_mask_i);  // R6 R8
      end
   end
   assign stat_rdata_o = stat_q;  // R6

   // ************************************************
   // Per-subcomponent clock enables
   // ************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sub_clk_en_o <= '0;
      end else begin
         for (int s = 0; s < SUBCOMP_COUNT; s++) begin
            sub_clk_en_o[s] <= sub_en_i[s]
                               && clk_src_en_i[sub_clk_sel_i[s*SUB_CLK_SEL_W +: SUB_CLK_SEL_W]]
                               && (!sub_ctrl_gate_i[s] || ctrl_q[sub_gate_bit_i[s*3 +: 3]]);  // R10 R9
         end
      end
   end

   // ************************************************
   // I/O port routing
   // ************************************************
   logic [PORT_PINS-1:0] out_pipe_q;
   logic [PORT_PINS-1:0] in_s1_q, in_s2_q, in_s3_q;
   logic [PORT_PINS-1:0] in_clean_q;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         out_pipe_q <= PINS_ZERO;
         in_s1_q    <= PINS_ZERO;
         in_s2_q    <= PINS_ZERO;
         in_s3_q    <= PINS_ZERO;
         in_clean_q <= PINS_ZERO;
         pin_drive_o <= '0;
      end else begin
         out_pipe_q <= port_out_data_i;                       // R12 R14
         in_s1_q    <= pin_in_i;                              // R13 R14
         in_s2_q    <= in_s1_q;
         in_s3_q    <= in_s2_q;
         in_clean_q <= (in_s2_q & in_s3_q) | (in_clean_q & (in_s2_q | in_s3_q));  // R13
         pin_drive_o <= port_drive_i;                         // R11
      end
   end

   // Bypass is combinational by design, for feed-through paths only
   assign pin_out_o = (port_out_pipe_i & out_pipe_q) | (~port_out_pipe_i & port_out_data_i);  // R12 R11
   assign port_in_data_o = (port_in_sync_i & in_clean_q) | (~port_in_sync_i & pin_in_i);     // R13

   always_comb begin
      pin_oe_o = PINS_ZERO;
      for (int p = 0; p < PORT_PINS; p++) begin
         case (port_oe_mode_i)
            OE_GANG_ALL: pin_oe_o[p] = port_oe_route_i[0];       // R16
            OE_GANG_2:   pin_oe_o[p] = port_oe_route_i[p / 4];   // R16
            OE_GANG_4:   pin_oe_o[p] = port_oe_route_i[p / 2];   // R16
            OE_SINGLE:   pin_oe_o[p] = (p < PORT_OE_COUNT) ? port_oe_route_i[p] : 1'b0;  // R16
            default:     pin_oe_o[p] = 1'b0;
         endcase
      end
   end
endmodule

// ### tb/logic_tile_routing_interface_monitor.sv
// Port assertions for the logic tile routing interface
module logic_tile_routing_interface_monitor
   import tile_routing_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       srst_i,
   input wire logic       ctrl_wr_i,
   input wire logic [7:0] ctrl_wdata_i,
   input wire logic [7:0] ctrl_route_o,
   input wire logic       stat_rd_i,
   input wire logic [7:0] stat_route_i,
   input wire logic [7:0] stat_sticky_mask_i,
   input wire logic [7:0] stat_rdata_o,
   input wire logic [3:0] sub_clk_en_o,
   input wire logic [7:0] dp_acc0_o,
   input wire logic [7:0] port_out_data_i,
   input wire logic [7:0] port_out_pipe_i,
   input wire logic [3:0] port_drive_i,
   input wire logic [3:0] port_oe_route_i,
   input wire logic [1:0] port_oe_mode_i,
   input wire logic [7:0] pin_out_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic [3:0] pin_drive_o,
   input wire logic [7:0] pin_in_i,
   input wire logic [7:0] port_in_sync_i,
   input wire logic [7:0] port_in_data_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   // ***********************
   // Rule checks
   // ***********************
   AST_CTRL_WRITE: assert property (ctrl_wr_i && sub_clk_en_o[3] |=> ctrl_route_o == $past(ctrl_wdata_i))
      else $error("control write lost");
   AST_CTRL_HOLD: assert property (!(ctrl_wr_i && sub_clk_en_o[3]) |=> $stable(ctrl_route_o))
      else $error("control changed without write");
   AST_RESET: assert property (disable iff (1'b0) srst_i |=> !ctrl_route_o && !stat_rdata_o && !sub_clk_en_o)
      else $error("outputs not cleared by reset");
   AST_STICKY_SET: assert property ((stat_sticky_mask_i[0] && stat_route_i[0]) ##1 stat_sticky_mask_i[0] |=> stat_rdata_o[0])
      else $error("held status bit lost");
   AST_STICKY_CLR: assert property ((stat_sticky_mask_i[0] && stat_rd_i && !stat_route_i[0]) ##1 (stat_sticky_mask_i[0] && !stat_route_i[0]) |=> !stat_rdata_o[0])
      else $error("held status bit not cleared");
   AST_STATUS_LIVE: assert property (1'b1 |=> !((stat_rdata_o ^ $past(stat_route_i)) & ~$past(stat_sticky_mask_i)))
      else $error("live status mismatch");
   AST_PIN_BYPASS: assert property (!((pin_out_o ^ port_out_data_i) & ~port_out_pipe_i))
      else $error("unpipelined pin mismatch");
   AST_PIN_PIPE: assert property (port_out_pipe_i[0] ##1 port_out_pipe_i[0] |-> pin_out_o[0] == $past(port_out_data_i[0]))
      else $error("pipelined pin mismatch");
   AST_IN_SYNC: assert property ((port_in_sync_i[0] && $stable(pin_in_i[0])) [*6] |-> port_in_data_o[0] == pin_in_i[0])
      else $error("synchronised input stuck");
   AST_IN_BYPASS: assert property (!((port_in_data_o ^ pin_in_i) & ~port_in_sync_i))
      else $error("bypassed input mismatch");
   AST_OE_GANG: assert property (port_oe_mode_i == OE_GANG_ALL |-> pin_oe_o == {8{port_oe_route_i[0]}})
      else $error("ganged enable mismatch");
   AST_DRIVE: assert property (1'b1 |=> pin_drive_o == $past(port_drive_i))
      else $error("drive routing mismatch");
   AST_DP_FROZEN: assert property (!sub_clk_en_o[2] |=> $stable(dp_acc0_o))
      else $error("datapath ran while disabled");
   cover property (stat_rd_i && stat_route_i[1]);
   cover property (port_oe_mode_i == OE_SINGLE);
   cover property (ctrl_wr_i && !sub_clk_en_o[3]);
endmodule
bind logic_tile_routing_interface logic_tile_routing_interface_monitor i_mon (.*);

// ### tb/routing_fabric_model.sv
// Stand-in for the routing fabric: status sources and pads
module routing_fabric_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] ev_req_i,
   input  wire logic [7:0] lvl_req_i,
   input  wire logic [7:0] pin_req_i,
   output logic      [7:0] stat_route_o,
   output logic      [7:0] pin_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial stat_route_o = 8'h00;
   initial pin_in_o = 8'h00;
   // One-cycle condition pulses ride on held levels
   always @(posedge sys_clk_i) stat_route_o <= ev_req_i | lvl_req_i;
   // Pads move off the clock grid, so the synchroniser is really exercised
   always @(pin_req_i) pin_in_o <= #17 pin_req_i;
endmodule

// ### tb/logic_tile_routing_interface_bench.sv
// Self-checking bench for the logic tile routing interface
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module logic_tile_routing_interface_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tile_routing_pkg::*;
   logic        sys_clk_i = 1'b0, srst_i = 1'b1, cfg_we_i = 1'b0, ctrl_wr_i = 1'b0, stat_rd_i = 1'b0;
   logic [2:0]  cfg_waddr_i = '0;
   logic [15:0] cfg_wdata_i = '0;
   logic [5:0]  dp_route_i = '0, dp_route_o;
   logic [11:0] dp_out_sel_i = '0, sub_gate_bit_i = '0;
   logic [1:0]  port_oe_mode_i = '0;
   logic [3:0]  clk_src_en_i = '0, sub_en_i = '0, sub_ctrl_gate_i = '0, port_drive_i = '0, port_oe_route_i = '0;
   logic [3:0]  sub_clk_en_o, pin_drive_o;
   logic [7:0]  dp_par_i = '0, ctrl_wdata_i = '0, stat_sticky_mask_i = '0, sub_clk_sel_i = '0, port_out_data_i = '0;
   logic [7:0]  port_out_pipe_i = '0, port_in_sync_i = '0, ev_q = '0, lvl_q = '0, pin_q = '0, exp_q, ctrl_m = '0;
   logic [7:0]  dp_acc0_o, ctrl_route_o, stat_rdata_o, stat_route_i, pin_out_o, pin_oe_o, pin_in_i, port_in_data_o;
   int          n_fail = 0, n_tests = 0, prev;
   int          pq[$] = {0};
   logic_tile_routing_interface i_dut (.*);
   routing_fabric_model i_fab (.sys_clk_i(sys_clk_i), .ev_req_i(ev_q), .lvl_req_i(lvl_q), .pin_req_i(pin_q),
                               .stat_route_o(stat_route_i), .pin_in_o(pin_in_i));
   always #25 sys_clk_i = ~sys_clk_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic results;
      $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Enable grouping: all eight, two nibbles, four pairs, pins 0..3 alone
   function automatic logic [7:0] oe_exp(input int m, input int r);
      logic [7:0] v = '0;
      for (int p = 0; p < 8; p++)
         if (m < 3 || p < 4) v[p] = r[m == 0 ? 0 : m == 1 ? p / 4 : m == 2 ? p / 2 : p];
      return v;
   endfunction
   // Generous bound: the tests need under 300 cycles
   initial begin
      #200us;
      n_fail++;
      $display("Error watchdog expected finish seen hang");
      results();
   end
   // ***********************
   // Test sequence
   // ***********************
   initial begin
      void'($urandom(32'h4AEF));
      cyc(16);
      srst_i <= 1'b0;
      #1;
      `CHK("ctrl reset", 8'h00, ctrl_route_o)
      $display("Test reset done");
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         clk_src_en_i <= 4'($urandom);
         sub_en_i <= 4'($urandom);
         sub_clk_sel_i <= 8'($urandom);
         cyc(2);
         #1;
         for (int k = 0; k < 4; k++)
            exp_q[k] = sub_en_i[k] & clk_src_en_i[sub_clk_sel_i[2*k+:2]];
         `CHK("clock enable", exp_q[3:0], sub_clk_en_o)
         cyc(1);
         ctrl_wr_i <= 1'b1;
         ctrl_wdata_i <= 8'($urandom);
         cyc(1);
         ctrl_wr_i <= 1'b0;
         if (exp_q[3]) ctrl_m = ctrl_wdata_i;
         cyc(1);
         #1;
         `CHK("control", ctrl_m, ctrl_route_o)
      end
      cyc(1);
      clk_src_en_i <= 4'hF;
      sub_en_i <= 4'hF;
      sub_clk_sel_i <= 8'hE4;
      sub_ctrl_gate_i <= 4'h4;
      sub_gate_bit_i <= 12'h080;
      for (int i = 0; i < 2; i++) begin
         cyc(1);
         ctrl_wr_i <= 1'b1;
         ctrl_wdata_i <= i ? 8'hFB : 8'h04;
         cyc(1);
         ctrl_wr_i <= 1'b0;
         cyc(2);
         #1;
         `CHK("gated enable", i ? 1'b0 : 1'b1, sub_clk_en_o[2])
      end
      $display("Test enables done");
      cyc(1);
      sub_ctrl_gate_i <= 4'h0;
      stat_sticky_mask_i <= 8'h0F;
      lvl_q <= 8'hA0;
      ev_q <= 8'h05;
      cyc(1);
      ev_q <= 8'h00;
      cyc(4);
      #1;
      `CHK("sticky", 8'hA5, stat_rdata_o)
      // Second pass reads with no new event, so the held bit must drop
      for (int i = 0; i < 2; i++) begin
         cyc(1);
         ev_q <= i ? 8'h00 : 8'h02;
         cyc(1);
         // Fabric lags one edge, so the read meets the event at the design
         ev_q <= 8'h00;
         stat_rd_i <= 1'b1;
         cyc(1);
         stat_rd_i <= 1'b0;
         cyc(3);
         #1;
         `CHK("read clear", i ? 8'hA0 : 8'hA2, stat_rdata_o)
      end
      $display("Test status done");
      for (int i = 0; i < 12; i++) begin
         cyc(1);
         prev = port_out_data_i;
         pq.push_back(8'($urandom));
         port_out_data_i <= 8'($urandom);
         port_out_pipe_i <= 8'($urandom);
         port_drive_i <= 4'($urandom);
         port_oe_route_i <= 4'($urandom);
         port_oe_mode_i <= 2'(i);
         port_in_sync_i <= 8'($urandom);
         pin_q <= 8'(pq[$]);
         #1;
         `CHK("pin out", (port_out_data_i & ~port_out_pipe_i) | (8'(prev) & port_out_pipe_i), pin_out_o)
         `CHK("enables", oe_exp(port_oe_mode_i, port_oe_route_i), pin_oe_o)
         #19;
         `CHK("pin in", (pin_q & ~port_in_sync_i) | (8'(pq[$-1]) & port_in_sync_i), port_in_data_o)
         cyc(6);
         #1;
         `CHK("drive", port_drive_i, pin_drive_o)
         `CHK("pin in settled", pin_q, port_in_data_o)
      end
      $display("Test pins done");
      // Quiet live status and drive first, so no check straddles the reset
      cyc(1);
      lvl_q <= 8'h00;
      port_drive_i <= 4'h0;
      for (int a = 0; a < 8; a++) begin
         cfg_we_i <= 1'b1;
         cfg_waddr_i <= 3'(a);
         cfg_wdata_i <= a ? 16'($urandom) : 16'h0101;
         cyc(1);
      end
      cfg_we_i <= 1'b0;
      srst_i <= 1'b1;
      cyc(2);
      srst_i <= 1'b0;
      #1;
      `CHK("reset enables", 4'h0, sub_clk_en_o)
      `CHK("ctrl reset again", 8'h00, ctrl_route_o)
      // Word 0 increments A0 of bank 0; enable returns one edge after reset
      prev = 5 + $urandom_range(15);
      cyc(prev + 1);
      #1;
      `CHK("accumulator", 8'(prev), dp_acc0_o)
      $display("Test increment done");
      for (int i = 0; i < 64; i++) begin
         cyc(1);
         cfg_we_i <= 1'($urandom);
         cfg_waddr_i <= 3'($urandom);
         cfg_wdata_i <= 16'($urandom);
         dp_route_i <= 6'($urandom);
         dp_par_i <= 8'($urandom);
         sub_en_i[2] <= 1'($urandom);
         dp_out_sel_i <= i < 32 ? 12'h000 : 12'($urandom);
         #1;
         if (i < 33) `CHK("route out", 6'h00, dp_route_o)
      end
      $display("Test datapath done");
      results();
   end
endmodule
